//--- hw/ebiops_top.sv
`timescale 1ns/1ns
// Overview of operation
// - eight pins, each with a data bit and direction bit at same position.
// - direction 1: data register read returns the stored latch bit.
// - direction 0: data register read returns the sampled pin level.
// - reset clears the output latch to zero.
// - direction 1 drives pin from latch; direction 0 makes it an input.
// - reset clears direction to zero, all pins inputs.
// - direction register is write-only and always reads all ones.
// - nonzero timer select makes pin 6 the compare output regardless of direction.
// - pins 7 and 3 to 0 follow only their own direction bit.
// - high-impedance in reset, standby and unknown mode codes, hold in sleep, subsleep and watch, normal in active and subactive.
module ebiops_top (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // register port
  input  wire logic [ebiops_pkg::ADDR_W-1:0]     reg_addr,
  input  wire logic [ebiops_pkg::DATA_W-1:0]     reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [ebiops_pkg::DATA_W-1:0]     reg_rdata,
  // operating mode from the power controller
  input  wire logic [2:0]                        op_mode,
  // timer connections
  input  wire logic [ebiops_pkg::TSEL_W-1:0]     timer_output_select,
  input  wire logic                              timer_compare_out,
  output logic                                   timer_clock_in,
  output logic                                   timer_reset_in,
  // port pins, split three ways
  input  wire logic [ebiops_pkg::PIN_N-1:0]      pin_in,
  output logic      [ebiops_pkg::PIN_N-1:0]      pin_out,
  output logic      [ebiops_pkg::PIN_N-1:0]      pin_oe
);
  import ebiops_pkg::*;

  // software-visible state
  logic [PIN_N-1:0] port_seven_output_latch;
  logic [PIN_N-1:0] port_seven_direction;

  // decode
  logic             hit_latch;
  logic             hit_dir;

  // mux results
  logic [PIN_N-1:0] drv_out;
  logic [PIN_N-1:0] drv_oe;
  logic [PIN_N-1:0] port_val;
  logic [DATA_W-1:0] next_rdata;

  // pin-state machine
  ebiops_state_e    state;
  ebiops_state_e    next_state;

  // address decode, exact match only
  // partial decode would alias the port onto its neighbours
  assign hit_latch = (reg_addr == OFF_OUTPUT_LATCH);
  assign hit_dir   = (reg_addr == OFF_DIRECTION);

  // output latch, one bit per pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_seven_output_latch <= RST_OUTPUT_LATCH;
    end else if (reg_wr && hit_latch) begin
      port_seven_output_latch <= reg_wdata;
    end
  end

  // direction bits, one per pin at the latch's bit position
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_seven_direction <= RST_DIRECTION;
    end else if (reg_wr && hit_dir) begin
      port_seven_direction <= reg_wdata;
    end
  end

  // drive selection per pin
  ebiops_pin_mux u_pin_mux (
    .latch   (port_seven_output_latch),
    .dir     (port_seven_direction),
    .tsel    (timer_output_select),
    .tcmp    (timer_compare_out),
    .drv_out (drv_out),
    .drv_oe  (drv_oe)
  );

  // read source per bit
  ebiops_rd_mux u_rd_mux (
    .latch     (port_seven_output_latch),
    .dir       (port_seven_direction),
    .pin_level (pin_in),
    .port_val  (port_val)
  );

  // read data selection; the direction register hides its contents
  always_comb begin
    next_rdata = RD_UNMAPPED;
    if (hit_latch) begin
      next_rdata = port_val;
    end else if (hit_dir) begin
      next_rdata = RD_DIRECTION;
    end
  end

  // read data stands only in the cycle after the strobe
  // zero outside the read cycle keeps a shared read bus quiet
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= RD_UNMAPPED;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= RD_UNMAPPED;
    end
  end

  // mode to pin state; unknown codes float the pins as the safe choice
  always_comb begin
    case (op_mode)
      MODE_ACTIVE:    next_state = ST_RUN;
      MODE_SUBACTIVE: next_state = ST_RUN;
      MODE_SLEEP:     next_state = ST_HOLD;
      MODE_SUBSLEEP:  next_state = ST_HOLD;
      MODE_WATCH:     next_state = ST_HOLD;
      MODE_STANDBY:   next_state = ST_HIZ;
      default:        next_state = ST_HIZ;
    endcase
  end

  // state register; reset parks in high impedance
  // it mirrors what the pin drivers saw one edge earlier
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_HIZ;
    end else begin
      state <= next_state;
    end
  end

  // pin drivers; hold keeps both value and enable frozen
  // next_state steers them so a mode change costs only one edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_oe  <= '0;
      pin_out <= '0;
    end else begin
      case (next_state)
        ST_RUN: begin
          pin_oe  <= drv_oe;
          pin_out <= drv_out;
        end
        ST_HOLD: begin
          pin_oe  <= pin_oe;
          pin_out <= pin_out;
        end
        ST_HIZ: begin
          pin_oe  <= '0;
          pin_out <= pin_out;
        end
        default: begin
          pin_oe  <= '0;
          pin_out <= pin_out;
        end
      endcase
    end
  end

  // timer inputs always see their pins, whatever the direction bits say
  // one flop of delay; the timer treats them as plain levels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_clock_in <= 1'b0;
      timer_reset_in <= 1'b0;
    end else begin
      timer_clock_in <= pin_in[PIN_CLK_IN];
      timer_reset_in <= pin_in[PIN_RST_IN];
    end
  end

  // checks on the register port and pins
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_latch_write;
    reg_wr && hit_latch;
  endsequence

  sequence s_dir_write;
    reg_wr && hit_dir;
  endsequence

  sequence s_latch_read;
    reg_rd && hit_latch && !reg_wr;
  endsequence

  sequence s_run_two;
    (op_mode == MODE_ACTIVE) [*2];
  endsequence

  sequence s_hold_two;
    (op_mode == MODE_SUBSLEEP || op_mode == MODE_WATCH) [*2];
  endsequence

  sequence s_sub_run;
    (op_mode == MODE_SUBACTIVE) [*2];
  endsequence

  // latch reads of an output pin return what was written
  a_latch_readback: assert property (
    (s_latch_write ##1 (reg_rd && hit_latch && port_seven_direction == 8'hff && !reg_wr))
    |=> (reg_rdata == $past(reg_wdata, 2))
  ) else $error("output latch readback mismatch");

  // latch reads of an input pin return the pin
  a_input_readback: assert property (
    (s_latch_read and (port_seven_direction == 8'h00))
    |=> (reg_rdata == $past(pin_in))
  ) else $error("input pin readback mismatch");

  // direction register reads as all ones whatever was written
  a_dir_reads_ones: assert property (
    (reg_rd && hit_dir) |=> (reg_rdata == RD_DIRECTION)
  ) else $error("direction register did not read all ones");

  // a direction write lands in the next cycle
  a_dir_write: assert property (
    s_dir_write |=> (port_seven_direction == $past(reg_wdata))
  ) else $error("direction write lost");

  // latch changes only through a latch write
  a_latch_stable: assert property (
    !(reg_wr && hit_latch) |=> $stable(port_seven_output_latch)
  ) else $error("output latch changed without a write");

  // two active cycles put pins 7 and 3 to 0 under their direction bits
  a_plain_drive: assert property (
    s_run_two |-> (pin_oe[3:0] == $past(port_seven_direction[3:0])
                   && pin_oe[7] == $past(port_seven_direction[7])
                   && pin_out[3:0] == $past(port_seven_output_latch[3:0]))
  ) else $error("plain pin drive does not follow direction");

  // nonzero timer select drives pin 6 with the compare output
  a_timer_pin: assert property (
    (timer_output_select != TSEL_GPIO && next_state == ST_RUN)
    |=> (pin_oe[PIN_CMP_OUT] && pin_out[PIN_CMP_OUT] == $past(timer_compare_out))
  ) else $error("pin 6 not handed to the timer");

  // zero timer select leaves pin 6 to its direction bit
  a_pin6_gpio: assert property (
    (timer_output_select == TSEL_GPIO && next_state == ST_RUN)
    |=> (pin_oe[PIN_CMP_OUT] == $past(port_seven_direction[PIN_CMP_OUT]))
  ) else $error("pin 6 ignores its direction bit");

  // standby floats every pin one cycle later
  a_standby_float: assert property (
    (op_mode == MODE_STANDBY) |=> (pin_oe == 8'h00)
  ) else $error("pins driven in standby");

  // sleep freezes the pins for as long as it lasts
  a_sleep_hold: assert property (
    (op_mode == MODE_SLEEP) [*2] |-> (pin_oe == $past(pin_oe) && pin_out == $past(pin_out))
  ) else $error("pins moved while held");

  // timer inputs follow their pins one cycle later
  a_timer_inputs: assert property (
    rst_n |=> (timer_clock_in == $past(pin_in[PIN_CLK_IN])
               && timer_reset_in == $past(pin_in[PIN_RST_IN]))
  ) else $error("timer input does not follow its pin");

  // no read strobe, no read data
  a_rdata_idle: assert property (
    !reg_rd |=> (reg_rdata == RD_UNMAPPED)
  ) else $error("read data without a read");

  // reset leaves pins floating and registers cleared
  a_reset_state: assert property (
    disable iff (1'b0)
    !rst_n |=> (pin_oe == 8'h00 && port_seven_output_latch == RST_OUTPUT_LATCH
                && port_seven_direction == RST_DIRECTION)
  ) else $error("reset state wrong");

  // a latch write lands in the next cycle
  a_latch_write: assert property (
    s_latch_write |=> (port_seven_output_latch == $past(reg_wdata))
  ) else $error("output latch write lost");

  // direction bits change only through a direction write
  a_dir_stable: assert property (
    !(reg_wr && hit_dir) |=> $stable(port_seven_direction)
  ) else $error("direction changed without a write");

  // writes to unmapped addresses touch neither register
  a_unmapped_write: assert property (
    (reg_wr && !hit_latch && !hit_dir)
    |=> ($stable(port_seven_output_latch) && $stable(port_seven_direction))
  ) else $error("unmapped write changed a register");

  // unmapped reads return the idle value
  a_unmapped_read: assert property (
    (reg_rd && !hit_latch && !hit_dir) |=> (reg_rdata == RD_UNMAPPED)
  ) else $error("unmapped read returned data");

  // zero timer select drives pin 6 from its latch bit
  a_pin6_latch: assert property (
    (timer_output_select == TSEL_GPIO && next_state == ST_RUN)
    |=> (pin_out[PIN_CMP_OUT] == $past(port_seven_output_latch[PIN_CMP_OUT]))
  ) else $error("pin 6 does not carry its latch bit");

  // subsleep and watch freeze the pins just as sleep does
  a_other_hold: assert property (
    s_hold_two |-> (pin_oe == $past(pin_oe) && pin_out == $past(pin_out))
  ) else $error("pins moved in subsleep or watch");

  // subactive runs the pins exactly like active
  a_subactive_run: assert property (
    s_sub_run |-> (pin_oe == $past(drv_oe) && pin_out == $past(drv_out))
  ) else $error("pins not functional in subactive");

  // the state register follows the decoded mode
  a_state_track: assert property (
    rst_n |=> (state == $past(next_state))
  ) else $error("pin state lags the mode");

  // a floating state never drives
  a_float_state: assert property (
    (state == ST_HIZ) |-> (pin_oe == 8'h00)
  ) else $error("pins driven while floating");

  // a held state never moves the pins
  a_hold_state: assert property (
    (state == ST_HOLD) |-> (pin_oe == $past(pin_oe) && pin_out == $past(pin_out))
  ) else $error("pins moved in the hold state");

  // reset clears read data, timer inputs and pin values
  a_reset_outputs: assert property (
    disable iff (1'b0)
    !rst_n |=> (reg_rdata == RD_UNMAPPED && !timer_clock_in && !timer_reset_in
                && pin_out == 8'h00)
  ) else $error("outputs not cleared in reset");

endmodule

//--- hw/ebiops_pkg.sv
package ebiops_pkg;

  // bus widths
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIN_N  = 8;

  // register offsets
  localparam logic [15:0] OFF_OUTPUT_LATCH = 16'hffda;
  localparam logic [15:0] OFF_DIRECTION    = 16'hffea;

  // reset and fixed read values
  localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] RST_DIRECTION    = 8'h00;
  localparam logic [7:0] RD_DIRECTION     = 8'hff;
  localparam logic [7:0] RD_UNMAPPED      = 8'h00;

  // shared pin positions
  localparam int unsigned PIN_CMP_OUT = 6;
  localparam int unsigned PIN_CLK_IN  = 5;
  localparam int unsigned PIN_RST_IN  = 4;

  // timer output-select field width and its plain-io value
  localparam int unsigned TSEL_W    = 4;
  localparam logic [3:0]  TSEL_GPIO = 4'h0;

  // operating mode codes on the mode input
  localparam logic [2:0] MODE_ACTIVE    = 3'h0;
  localparam logic [2:0] MODE_SUBACTIVE = 3'h1;
  localparam logic [2:0] MODE_SLEEP     = 3'h2;
  localparam logic [2:0] MODE_SUBSLEEP  = 3'h3;
  localparam logic [2:0] MODE_STANDBY   = 3'h4;
  localparam logic [2:0] MODE_WATCH     = 3'h5;

  // pin-state machine, one-hot
  typedef enum logic [2:0] {
    ST_HIZ  = 3'b001,
    ST_RUN  = 3'b010,
    ST_HOLD = 3'b100
  } ebiops_state_e;

endpackage

//--- hw/ebiops_pin_mux.sv
`timescale 1ns/1ns
// per-pin drive selection from latch, direction and timer select
module ebiops_pin_mux (
  // software state
  input  wire logic [ebiops_pkg::PIN_N-1:0]  latch,
  input  wire logic [ebiops_pkg::PIN_N-1:0]  dir,
  // timer side
  input  wire logic [ebiops_pkg::TSEL_W-1:0] tsel,
  input  wire logic                          tcmp,
  // wanted drive
  output logic      [ebiops_pkg::PIN_N-1:0]  drv_out,
  output logic      [ebiops_pkg::PIN_N-1:0]  drv_oe
);
  import ebiops_pkg::*;

  logic timer_owns;

  // any nonzero select hands pin 6 to the timer
  assign timer_owns = (tsel != TSEL_GPIO);

  // every other pin follows only its own direction bit
  for (genvar i = 0; i < PIN_N; i++) begin : g_pin
    if (i == PIN_CMP_OUT) begin : g_shared
      assign drv_out[i] = timer_owns ? tcmp : latch[i];
      assign drv_oe[i]  = timer_owns ? 1'b1 : dir[i];
    end else begin : g_plain
      assign drv_out[i] = latch[i];
      assign drv_oe[i]  = dir[i];
    end
  end

endmodule

//--- hw/ebiops_rd_mux.sv
`timescale 1ns/1ns
// per-bit read source: latch for outputs, pin level for inputs
module ebiops_rd_mux (
  // sources
  input  wire logic [ebiops_pkg::PIN_N-1:0] latch,
  input  wire logic [ebiops_pkg::PIN_N-1:0] dir,
  input  wire logic [ebiops_pkg::PIN_N-1:0] pin_level,
  // result
  output logic      [ebiops_pkg::PIN_N-1:0] port_val
);
  import ebiops_pkg::*;

  for (genvar i = 0; i < PIN_N; i++) begin : g_bit
    // output pins read back the latch, not the wire
    assign port_val[i] = dir[i] ? latch[i] : pin_level[i];
  end

endmodule

//--- dv/ebiops_pin_model.sv
`timescale 1ns/1ns
// board side of the port: holds a level on every pin the device leaves alone
module ebiops_pin_model (
  // device drive
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // level the board puts on undriven pins
  input  wire logic [7:0] board_val,
  // resolved pin level
  output logic      [7:0] pin_in
);
  // a driven pin shows the device level, an undriven one the board level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : board_val[i];
    end
  end
endmodule

//--- dv/eight_bit_io_port_seven_tb_top.sv
`timescale 1ns/1ns
module eight_bit_io_port_seven_tb_top;
  import ebiops_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tcmp = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, board = 8'h00, rdata, pout, poe, pin_in, v, sv_oe, sv_out;
  logic [3:0]  tsel = 4'h0;
  logic [2:0]  mode = MODE_ACTIVE;
  logic        tclk, trst;
  int          err_total = 0, check_count = 0, seed = 32'h1ea72911, lat = 0, dir = 0;
  logic [2:0]  hold_modes [3] = '{MODE_SLEEP, MODE_SUBSLEEP, MODE_WATCH};

  ebiops_top u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .op_mode(mode),
    .timer_output_select(tsel), .timer_compare_out(tcmp), .timer_clock_in(tclk),
    .timer_reset_in(trst), .pin_in(pin_in), .pin_out(pout), .pin_oe(poe));
  ebiops_pin_model u_board (.pin_out(pout), .pin_oe(poe), .board_val(board), .pin_in(pin_in));

  initial begin
    forever #2 clk = ~clk;
  end

  // reference model of the wanted pin drive and read value
  function automatic logic [7:0] e_oe();
    return (tsel != 4'h0) ? (8'(dir) | 8'h40) : 8'(dir);
  endfunction
  function automatic logic [7:0] e_out();
    return (tsel != 4'h0) ? ((8'(lat) & 8'hbf) | {1'b0, tcmp, 6'h00}) : 8'(lat);
  endfunction
  function automatic logic [7:0] e_pin();
    return (e_oe() & e_out()) | (~e_oe() & board);
  endfunction

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == OFF_OUTPUT_LATCH) lat = d;
    if (a == OFF_DIRECTION) dir = d;
  endtask

  // read data stand only in the cycle after the read edge
  task automatic rd(logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // write then read with no gap between the strobes
  task automatic wr_rd(logic [15:0] a, logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    q = rdata;
    if (a == OFF_OUTPUT_LATCH) lat = d;
  endtask

  task automatic pins();
    logic [7:0] p;
    repeat (2) @(posedge clk);
    #1;
    p = e_pin();
    chk("pin_oe", poe, e_oe());
    chk("pin_out", pout & e_oe(), e_out() & e_oe());
    chk("timer inputs", {6'h00, tclk, trst}, {6'h00, p[5], p[4]});
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk("pin_oe in reset", poe, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    lat = 0;
    dir = 0;
    pins();
    rd(OFF_OUTPUT_LATCH, v);
    chk("input read after reset", v, e_pin());
    wr(OFF_DIRECTION, 8'hff);
    rd(OFF_OUTPUT_LATCH, v);
    chk("latch after reset", v, 8'h00);
    wr_rd(OFF_OUTPUT_LATCH, 8'($random(seed)), v);
    chk("latch readback", v, 8'(lat));
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    do_reset();
    for (int k = 0; k < 24; k++) begin
      @(posedge clk);
      board <= 8'($random(seed));
      tsel  <= (k % 3 == 0) ? 4'($random(seed)) : 4'h0;
      tcmp  <= 1'($random(seed));
      wr(OFF_OUTPUT_LATCH, 8'($random(seed)));
      wr(OFF_DIRECTION, 8'($random(seed)));
      wr(16'hffdb, 8'($random(seed)));
      pins();
      rd(OFF_OUTPUT_LATCH, v);
      chk("latch read", v, (8'(dir) & 8'(lat)) | (~8'(dir) & e_pin()));
      rd(OFF_DIRECTION, v);
      chk("direction read", v, 8'hff);
      rd(16'hffdb, v);
      chk("unmapped read", v, 8'h00);
    end
    // hold modes freeze the pins; leaving them lets the new setting through
    foreach (hold_modes[m]) begin
      @(posedge clk);
      mode <= hold_modes[m];
      pins();
      sv_oe  = poe;
      sv_out = pout;
      wr(OFF_OUTPUT_LATCH, 8'($random(seed)));
      wr(OFF_DIRECTION, ~8'(dir));
      repeat (2) @(posedge clk);
      #1;
      chk("held oe", poe, sv_oe);
      chk("held out", pout, sv_out);
      @(posedge clk);
      mode <= MODE_ACTIVE;
      pins();
    end
    sv_out = pout;
    @(posedge clk);
    mode <= MODE_STANDBY;
    repeat (2) @(posedge clk);
    #1;
    chk("standby oe", poe, 8'h00);
    chk("standby out", pout, sv_out);
    @(posedge clk);
    mode <= MODE_ACTIVE;
    pins();
    @(posedge clk);
    mode <= 3'h7;
    repeat (2) @(posedge clk);
    #1;
    chk("float code oe", poe, 8'h00);
    @(posedge clk);
    mode <= MODE_SUBACTIVE;
    wr(OFF_OUTPUT_LATCH, 8'($random(seed)));
    pins();
    do_reset();
    print_verdict();
  end
endmodule
